// file: verilog/scf_pkg.sv
// Shared constants and carrier types for the single-clock FIFO block.
// Assumes one clock domain and an AXI4-Lite register port with 32-bit data.
//
// What this block does
// - Fill count wraps at sixteen; full flag disambiguates.
// - Legacy write clears empty, bumps count same edge.
// - Simultaneous read and write keeps count unchanged when neither full nor empty.
// - Near-empty high while count below five.
// - Near-full high while count at least twelve.
// - Asynchronous clear empties at once, count zero.
// - Legacy output word survives an asynchronous clear.
// - Requests ignored during asynchronous clear.
// - Synchronous clear empties and discards on edge.
// - Full flag rises on the filling write edge.
// - Writes ignored while full with overflow checking.
// - Legacy read shows oldest word, decrements, unfulls.
// - Last read shows word and sets empty together.
// - Legacy output changes only on honoured reads.
// - Fall-through mode shows oldest word; read acknowledges.
// - Fall-through shows first word one edge later.
// - Fall-through read shows next word immediately.

package scf_pkg;

  // ----------------------------------------------------------------
  // Geometry and thresholds
  // ----------------------------------------------------------------
  localparam int unsigned DATA_W = 8;
  localparam int unsigned PTR_W  = 4;
  localparam int unsigned LVL_W  = 5;
  localparam int unsigned ADDR_W = 8;
  localparam int unsigned N_EV   = 4;

  typedef logic [LVL_W-1:0]  scf_lvl_t;
  typedef logic [PTR_W-1:0]  scf_ptr_t;
  typedef logic [DATA_W-1:0] scf_data_t;

  localparam scf_lvl_t LVL_DEPTH      = 5'h10;
  localparam scf_lvl_t LVL_NEAR_FULL  = 5'h0c;
  localparam scf_lvl_t LVL_NEAR_EMPTY = 5'h05;

  // ----------------------------------------------------------------
  // Register map (byte addresses) and field positions
  // ----------------------------------------------------------------
  localparam logic [ADDR_W-1:0] OFF_CTRL     = 8'h00;
  localparam logic [ADDR_W-1:0] OFF_STATUS   = 8'h04;
  localparam logic [ADDR_W-1:0] OFF_IRQ_STAT = 8'h08;
  localparam logic [ADDR_W-1:0] OFF_IRQ_MASK = 8'h0c;

  localparam int unsigned CTRL_FWFT_BIT  = 0;
  localparam int unsigned CTRL_OVF_BIT   = 1;
  localparam int unsigned CTRL_UDF_BIT   = 2;
  localparam int unsigned CTRL_CLEAR_BIT = 3;

  localparam int unsigned EV_OVERFLOW  = 0;
  localparam int unsigned EV_UNDERFLOW = 1;
  localparam int unsigned EV_FULL      = 2;
  localparam int unsigned EV_NEAR_FULL = 3;

  localparam logic [1:0] RESP_OKAY   = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  // ----------------------------------------------------------------
  // Carrier types
  // ----------------------------------------------------------------
  typedef struct packed {
    logic udf_chk;
    logic ovf_chk;
    logic fwft;
  } scf_ctrl_s;

  // Packed so that full lands in bit 4 of the status word.
  typedef struct packed {
    logic near_empty;
    logic near_full;
    logic empty;
    logic full;
  } scf_flags_s;

  localparam scf_ctrl_s  CTRL_RST  = 3'h6;
  localparam scf_flags_s FLAGS_RST = 4'ha;

endpackage : scf_pkg

// file: verilog/scf_irq.sv
// Sticky interrupt status with write-one-to-clear, mask and level output.
// Assumes events are one-cycle pulses on the same clock.
`timescale 1ns/1ps

module scf_irq
(
  input  wire logic                     aclk,
  input  wire logic                     aresetn,
  input  wire logic [scf_pkg::N_EV-1:0] event_pulse,
  input  wire logic                     clr_we,
  input  wire logic                     mask_we,
  input  wire logic [scf_pkg::N_EV-1:0] wr_bits,
  output logic      [scf_pkg::N_EV-1:0] stat_q,
  output logic      [scf_pkg::N_EV-1:0] mask_q,
  output logic                          irq_q
);

  // ----------------------------------------------------------------
  // Status bits
  // ----------------------------------------------------------------
  // A set in the clearing cycle wins, so no event is lost.
  genvar gi;
  generate
    for (gi = 0; gi < scf_pkg::N_EV; gi++)
    begin : g_bit
      always_ff @(posedge aclk)
      begin
        if (!aresetn)
          stat_q[gi] <= 1'b0;
        else if (event_pulse[gi])
          stat_q[gi] <= 1'b1;
        else if (clr_we && wr_bits[gi])
          stat_q[gi] <= 1'b0;
      end
    end
  endgenerate

  // Mask register; a one lets the status bit reach the output.
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
      mask_q <= '0;
    else if (mask_we)
      mask_q <= wr_bits;
  end

  // Registered output lags the status bits by one edge.
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
      irq_q <= 1'b0;
    else
      irq_q <= |(stat_q & mask_q);
  end

endmodule : scf_irq

// file: verilog/scf_fifo.sv
// Single-clock 8x16 FIFO with legacy and fall-through read modes.
// Assumes producer and consumer share aclk; async_clear may arrive anytime.
//
// Implementation choices: the address map and the AXI4-Lite interface to the registers.
`timescale 1ns/1ps

module scf_fifo
(
  input  wire logic                          aclk,
  input  wire logic                          aresetn,
  input  wire logic                          async_clear,
  input  wire logic                          sync_clear,
  input  wire logic                          write_request,
  input  wire logic [scf_pkg::DATA_W-1:0]    write_data,
  input  wire logic                          read_request,
  output logic      [scf_pkg::DATA_W-1:0]    read_data_out,
  output logic      [scf_pkg::PTR_W-1:0]     fill_count,
  output logic                               full_flag,
  output logic                               empty_flag,
  output logic                               near_full_flag,
  output logic                               near_empty_flag,
  output logic                               irq,
  input  wire logic [scf_pkg::ADDR_W-1:0]    awaddr,
  input  wire logic                          awvalid,
  output logic                               awready,
  input  wire logic [31:0]                   wdata,
  input  wire logic [3:0]                    wstrb,
  input  wire logic                          wvalid,
  output logic                               wready,
  output logic      [1:0]                    bresp,
  output logic                               bvalid,
  input  wire logic                          bready,
  input  wire logic [scf_pkg::ADDR_W-1:0]    araddr,
  input  wire logic                          arvalid,
  output logic                               arready,
  output logic      [31:0]                   rdata,
  output logic      [1:0]                    rresp,
  output logic                               rvalid,
  input  wire logic                          rready
);

  // ----------------------------------------------------------------
  // Declarations
  // ----------------------------------------------------------------
  scf_pkg::scf_data_t                mem [16];
  scf_pkg::scf_ptr_t                 wr_ptr_q;
  scf_pkg::scf_ptr_t                 rd_ptr_q;
  scf_pkg::scf_lvl_t                 level_q;
  scf_pkg::scf_lvl_t                 level_d;
  scf_pkg::scf_lvl_t                 mem_cnt_q;
  scf_pkg::scf_lvl_t                 mem_cnt_d;
  logic                              show_q;
  logic                              show_d;
  scf_pkg::scf_flags_s               flags_q;
  scf_pkg::scf_flags_s               flags_d;
  scf_pkg::scf_data_t                rdout_q;
  scf_pkg::scf_ctrl_s                ctrl_q;
  logic                              wr_ok;
  logic                              wr_eff;
  logic                              rd_ok;
  logic                              rd_eff;
  logic                              load;
  logic                              pop;
  logic                              take_word;
  logic                              clear_now;
  logic [scf_pkg::N_EV-1:0]          events;
  logic [scf_pkg::N_EV-1:0]          irq_stat;
  logic [scf_pkg::N_EV-1:0]          irq_mask;
  logic                              irq_q;
  logic [scf_pkg::ADDR_W-1:0]        awaddr_q;
  logic [7:0]                        wbyte_q;
  logic                              wstrb0_q;
  logic                              aw_have_q;
  logic                              w_have_q;
  logic                              awready_q;
  logic                              wready_q;
  logic                              bvalid_q;
  logic [1:0]                        bresp_q;
  logic                              arready_q;
  logic                              rvalid_q;
  logic [1:0]                        rresp_q;
  logic [31:0]                       rdata_q;
  logic                              reg_we;
  logic                              we_ctrl;
  logic                              we_clr;
  logic                              we_mask;
  logic                              soft_clear;
  logic                              wr_mapped;
  logic                              rd_mapped;
  logic [31:0]                       rd_word;

  // ----------------------------------------------------------------
  // Request qualification and next state
  // ----------------------------------------------------------------
  // Both request paths are blocked outright while the asynchronous clear
  // is high, so the memory array cannot be written behind its back.
  always_comb
  begin
    wr_ok = write_request && !async_clear
            && !(ctrl_q.ovf_chk && flags_q.full);
    rd_ok = read_request && !async_clear
            && !(ctrl_q.udf_chk && flags_q.empty);
    // Without checking, a read of nothing or a write past sixteen is
    // still dropped so the count cannot run away.
    if (ctrl_q.fwft)
      rd_eff = rd_ok && show_q;
    else
      rd_eff = rd_ok && (mem_cnt_q != '0);
    wr_eff    = wr_ok && ((level_q != scf_pkg::LVL_DEPTH) || rd_eff);
    load      = (!show_q || rd_eff) && (mem_cnt_q != '0);
    pop       = ctrl_q.fwft ? load : rd_eff;
    take_word = ctrl_q.fwft ? load : rd_eff;
    show_d    = ctrl_q.fwft && (load || (show_q && !rd_eff));
    level_d   = level_q + scf_pkg::scf_lvl_t'(wr_eff)
                - scf_pkg::scf_lvl_t'(rd_eff);
    mem_cnt_d = mem_cnt_q + scf_pkg::scf_lvl_t'(wr_eff)
                - scf_pkg::scf_lvl_t'(pop);
    flags_d.full       = (level_d == scf_pkg::LVL_DEPTH);
    flags_d.empty      = ctrl_q.fwft ? !show_d : (level_d == '0);
    flags_d.near_full  = (level_d >= scf_pkg::LVL_NEAR_FULL);
    flags_d.near_empty = (level_d <  scf_pkg::LVL_NEAR_EMPTY);
  end

  assign clear_now = sync_clear || soft_clear;

  // ----------------------------------------------------------------
  // Storage
  // ----------------------------------------------------------------
  // The array has no reset; pointers and counts define what is valid.
  always_ff @(posedge aclk)
  begin
    if (wr_eff && !clear_now)
      mem[wr_ptr_q] <= write_data;
  end

  // Pointers, counts and flags fall back to empty at once on the
  // asynchronous clear and on the edge of a synchronous clear.
  always_ff @(posedge aclk or posedge async_clear)
  begin
    if (async_clear)
    begin
      wr_ptr_q  <= '0;
      rd_ptr_q  <= '0;
      level_q   <= '0;
      mem_cnt_q <= '0;
      show_q    <= 1'b0;
      flags_q   <= scf_pkg::FLAGS_RST;
    end
    else if (!aresetn || clear_now)
    begin
      wr_ptr_q  <= '0;
      rd_ptr_q  <= '0;
      level_q   <= '0;
      mem_cnt_q <= '0;
      show_q    <= 1'b0;
      flags_q   <= scf_pkg::FLAGS_RST;
    end
    else
    begin
      wr_ptr_q  <= wr_ptr_q + scf_pkg::scf_ptr_t'(wr_eff);
      rd_ptr_q  <= rd_ptr_q + scf_pkg::scf_ptr_t'(pop);
      level_q   <= level_d;
      mem_cnt_q <= mem_cnt_d;
      show_q    <= show_d;
      flags_q   <= flags_d;
    end
  end

  // The output word is not touched by either clear, so the last word
  // read stays visible until take_word next loads a word from the array.
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
      rdout_q <= '0;
    else if (take_word && !clear_now && !async_clear)
      rdout_q <= mem[rd_ptr_q];
  end

  // Count port shows the low four bits, so sixteen reads as zero.
  assign fill_count      = level_q[scf_pkg::PTR_W-1:0];
  assign full_flag       = flags_q.full;
  assign empty_flag      = flags_q.empty;
  assign near_full_flag  = flags_q.near_full;
  assign near_empty_flag = flags_q.near_empty;
  assign read_data_out   = rdout_q;

  // ----------------------------------------------------------------
  // Interrupt events
  // ----------------------------------------------------------------
  // Threshold crossings are one-cycle pulses; a refused request raises its event on every cycle it is held.
  always_comb
  begin
    events                         = '0;
    events[scf_pkg::EV_OVERFLOW]   = write_request && !async_clear
                                     && ctrl_q.ovf_chk && flags_q.full;
    events[scf_pkg::EV_UNDERFLOW]  = read_request && !async_clear
                                     && ctrl_q.udf_chk && flags_q.empty;
    events[scf_pkg::EV_FULL]       = !async_clear && !clear_now
                                     && flags_d.full && !flags_q.full;
    events[scf_pkg::EV_NEAR_FULL]  = !async_clear && !clear_now
                                     && flags_d.near_full && !flags_q.near_full;
  end

  scf_irq u_irq
  (
    .aclk        (aclk),
    .aresetn     (aresetn),
    .event_pulse (events),
    .clr_we      (we_clr),
    .mask_we     (we_mask),
    .wr_bits     (wbyte_q[scf_pkg::N_EV-1:0]),
    .stat_q      (irq_stat),
    .mask_q      (irq_mask),
    .irq_q       (irq_q)
  );

  assign irq = irq_q;

  // ----------------------------------------------------------------
  // AXI4-Lite write channel
  // ----------------------------------------------------------------
  // Address and data are taken independently and held until both are
  // here; one write at a time keeps the slave simple.
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      awready_q <= 1'b1;
      wready_q  <= 1'b1;
      aw_have_q <= 1'b0;
      w_have_q  <= 1'b0;
      bvalid_q  <= 1'b0;
      bresp_q   <= scf_pkg::RESP_OKAY;
      awaddr_q  <= '0;
      wbyte_q   <= '0;
      wstrb0_q  <= 1'b0;
    end
    else
    begin
      if (awvalid && awready_q)
      begin
        awaddr_q  <= awaddr;
        aw_have_q <= 1'b1;
        awready_q <= 1'b0;
      end
      if (wvalid && wready_q)
      begin
        wbyte_q  <= wdata[7:0];
        wstrb0_q <= wstrb[0];
        w_have_q <= 1'b1;
        wready_q <= 1'b0;
      end
      if (reg_we)
      begin
        aw_have_q <= 1'b0;
        w_have_q  <= 1'b0;
        bvalid_q  <= 1'b1;
        bresp_q   <= wr_mapped ? scf_pkg::RESP_OKAY : scf_pkg::RESP_SLVERR;
      end
      if (bvalid_q && bready)
      begin
        bvalid_q  <= 1'b0;
        awready_q <= 1'b1;
        wready_q  <= 1'b1;
      end
    end
  end

  // All fields live in byte lane 0; other lanes are ignored.
  always_comb
  begin
    reg_we     = aw_have_q && w_have_q && !bvalid_q;
    wr_mapped  = (awaddr_q == scf_pkg::OFF_CTRL)
                 || (awaddr_q == scf_pkg::OFF_STATUS)
                 || (awaddr_q == scf_pkg::OFF_IRQ_STAT)
                 || (awaddr_q == scf_pkg::OFF_IRQ_MASK);
    we_ctrl    = reg_we && wstrb0_q && (awaddr_q == scf_pkg::OFF_CTRL);
    we_clr     = reg_we && wstrb0_q && (awaddr_q == scf_pkg::OFF_IRQ_STAT);
    we_mask    = reg_we && wstrb0_q && (awaddr_q == scf_pkg::OFF_IRQ_MASK);
    soft_clear = we_ctrl && wbyte_q[scf_pkg::CTRL_CLEAR_BIT];
  end

  // Mode and checking switches; change the mode only while empty.
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
      ctrl_q <= scf_pkg::CTRL_RST;
    else if (we_ctrl)
    begin
      ctrl_q.fwft    <= wbyte_q[scf_pkg::CTRL_FWFT_BIT];
      ctrl_q.ovf_chk <= wbyte_q[scf_pkg::CTRL_OVF_BIT];
      ctrl_q.udf_chk <= wbyte_q[scf_pkg::CTRL_UDF_BIT];
    end
  end

  assign awready = awready_q;
  assign wready  = wready_q;
  assign bvalid  = bvalid_q;
  assign bresp   = bresp_q;

  // ----------------------------------------------------------------
  // AXI4-Lite read channel
  // ----------------------------------------------------------------
  // Read data mux; the clear command bit always reads back as zero.
  always_comb
  begin
    rd_word   = '0;
    rd_mapped = 1'b1;
    unique case (araddr)
      scf_pkg::OFF_CTRL:
        rd_word[2:0] = ctrl_q;
      scf_pkg::OFF_STATUS:
        rd_word[7:0] = {flags_q, level_q[scf_pkg::PTR_W-1:0]};
      scf_pkg::OFF_IRQ_STAT:
        rd_word[scf_pkg::N_EV-1:0] = irq_stat;
      scf_pkg::OFF_IRQ_MASK:
        rd_word[scf_pkg::N_EV-1:0] = irq_mask;
      default:
        rd_mapped = 1'b0;
    endcase
  end

  // One read at a time; data is captured on the address handshake.
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      arready_q <= 1'b1;
      rvalid_q  <= 1'b0;
      rresp_q   <= scf_pkg::RESP_OKAY;
      rdata_q   <= '0;
    end
    else if (arvalid && arready_q)
    begin
      arready_q <= 1'b0;
      rvalid_q  <= 1'b1;
      rdata_q   <= rd_word;
      rresp_q   <= rd_mapped ? scf_pkg::RESP_OKAY : scf_pkg::RESP_SLVERR;
    end
    else if (rvalid_q && rready)
    begin
      rvalid_q  <= 1'b0;
      arready_q <= 1'b1;
    end
  end

  assign arready = arready_q;
  assign rvalid  = rvalid_q;
  assign rdata   = rdata_q;
  assign rresp   = rresp_q;

endmodule : scf_fifo

// file: dv/scf_fifo_assertions.sv
// Assertions on the stream flags and fill count of scf_fifo.
// Assumes a bind to scf_fifo; sees only its ports.
`timescale 1ns/1ps

module scf_fifo_assertions
(
  input wire logic       aclk,
  input wire logic       aresetn,
  input wire logic       async_clear,
  input wire logic       sync_clear,
  input wire logic       write_request,
  input wire logic       read_request,
  input wire logic [3:0] fill_count,
  input wire logic       full_flag,
  input wire logic       empty_flag,
  input wire logic       near_full_flag,
  input wire logic       near_empty_flag
);
  // --------------------
  // Clocking and shapes
  // --------------------
  // The asynchronous clear moves state between edges, so it stands down every check but aclr_flags_a.
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn || async_clear);
  sequence s_wr;
    write_request && !read_request && !full_flag && !sync_clear;
  endsequence
  sequence s_rd;
    read_request && !write_request && !empty_flag && !sync_clear;
  endsequence
  // --------------------
  // Assertions
  // --------------------
  wr_count_a: assert property (s_wr |=> fill_count == 4'($past(fill_count) + 4'h1))
    else $error("count did not rise on a write");
  rw_hold_a: assert property (write_request && read_request && !full_flag && !empty_flag
    && !sync_clear |=> $stable(fill_count)) else $error("count moved on read with write");
  near_empty_a: assert property (near_empty_flag == (!full_flag && fill_count < 4'h5))
    else $error("near empty flag wrong");
  near_full_a: assert property (near_full_flag == (full_flag || fill_count >= 4'hc))
    else $error("near full flag wrong");
  aclr_flags_a: assert property (disable iff (!aresetn) async_clear |-> empty_flag
    && near_empty_flag && !full_flag && fill_count == 4'h0) else $error("clear not at once");
  sclr_flags_a: assert property (sync_clear |=> empty_flag && near_empty_flag
    && fill_count == 4'h0) else $error("sync clear missed");
  full_wrap_a: assert property (s_wr ##0 fill_count == 4'hf |=> full_flag
    && fill_count == 4'h0) else $error("full not on filling write");
  ovf_hold_a: assert property (full_flag && write_request && !read_request && !sync_clear
    |=> full_flag && fill_count == 4'h0) else $error("write taken while full");
  rd_count_a: assert property (s_rd |=> !full_flag
    && fill_count == 4'($past(fill_count) - 4'h1)) else $error("read did not count down");
  last_rd_a: assert property (s_rd ##0 fill_count == 4'h1 |=> empty_flag
    && fill_count == 4'h0) else $error("last read left not empty");
  udf_hold_a: assert property (empty_flag && fill_count == 4'h0 && read_request
    && !write_request |=> empty_flag) else $error("read taken while empty");
endmodule : scf_fifo_assertions

bind scf_fifo scf_fifo_assertions scf_fifo_assertions_inst (.aclk, .aresetn, .async_clear,
  .sync_clear, .write_request, .read_request, .fill_count, .full_flag, .empty_flag,
  .near_full_flag, .near_empty_flag);

// file: dv/scf_partner.sv
// Producer and consumer model on the stream side of scf_fifo.
// Assumes the bench moves wr_on and rd_on just after a rising edge of aclk.
`timescale 1ns/1ps

module scf_partner
(
  input  wire logic       aclk,
  input  wire logic       aresetn,
  input  wire logic       wr_on,
  input  wire logic       rd_on,
  input  wire logic       full_flag,
  output logic            write_request,
  output logic [7:0]      write_data,
  output logic            read_request
);
  logic [7:0] word_q;

  // Requests follow the bench with no lag; idle data shows the inverse, never a stale word.
  assign write_request = wr_on;
  assign read_request  = rd_on;
  assign write_data    = wr_on ? word_q : ~word_q;

  // The word advances on every write made while full_flag is low, including writes dropped during a clear.
  always_ff @(posedge aclk)
    if (!aresetn) word_q <= 8'h01;
    else if (wr_on && !full_flag) word_q <= word_q + 8'h01;
endmodule : scf_partner

// file: dv/scf_fifo_tb_top.sv
// Bench for scf_fifo: stream, clears, read modes, registers and interrupt.
// Assumes scf_partner on the stream side; the bench is the AXI4-Lite master.
`timescale 1ns/1ps

module scf_fifo_tb_top;
  // --------------------
  // Signals
  // --------------------
  logic        aclk = 1'b0, aresetn = 1'b0, async_clear = 1'b0, sync_clear = 1'b0;
  logic        wr_on = 1'b0, rd_on = 1'b0, awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0;
  logic        arvalid = 1'b0, rready = 1'b0, write_request, read_request, irq, full_flag;
  logic        empty_flag, near_full_flag, near_empty_flag, awready, wready, bvalid;
  logic        arready, rvalid;
  logic [7:0]  write_data, read_data_out, awaddr = 8'h00, araddr = 8'h00, m_rd = 8'h00;
  logic [7:0]  mq[$];
  logic [3:0]  fill_count;
  logic [1:0]  bresp, rresp;
  logic [31:0] wdata = 32'h0, rdata;
  bit          mon_en, wok;
  int          fails, num_checks, cycles;

  // Clock with a 50 ns period.
  always #25 aclk = ~aclk;

  scf_fifo scf_fifo_inst (.aclk, .aresetn, .async_clear, .sync_clear, .write_request,
    .write_data, .read_request, .read_data_out, .fill_count, .full_flag, .empty_flag,
    .near_full_flag, .near_empty_flag, .irq, .awaddr, .awvalid, .awready, .wdata,
    .wstrb(4'hf), .wvalid, .wready, .bresp, .bvalid, .bready, .araddr, .arvalid, .arready,
    .rdata, .rresp, .rvalid, .rready);
  scf_partner scf_partner_inst (.aclk, .aresetn, .wr_on, .rd_on, .full_flag, .write_request,
    .write_data, .read_request);

  // --------------------
  // Checking and bus tasks
  // --------------------
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    num_checks++;
    if (got !== exp)
    begin
      fails++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk

  task automatic finish_test();
    $display("checks %0d mismatches %0d", num_checks, fails);
    if (fails == 0 && num_checks > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask : finish_test

  task automatic run(input logic w, input logic r, input int n);
    wr_on <= w;
    rd_on <= r;
    repeat (n) @(posedge aclk);
  endtask : run

  task automatic axi_wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] r);
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    do
    begin
      @(posedge aclk);
      if (awvalid && awready) awvalid <= 1'b0;
      if (wvalid && wready) wvalid <= 1'b0;
      if (bvalid && bready) bready <= 1'b0;
      if (bvalid && bready) chk(32'(bresp), 32'(r));
    end
    while (awvalid || wvalid || bready);
  endtask : axi_wr

  task automatic axi_rd(input logic [7:0] a, input logic [31:0] d, input logic [1:0] r);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    do
    begin
      @(posedge aclk);
      if (arvalid && arready) arvalid <= 1'b0;
      if (rvalid && rready) rready <= 1'b0;
      if (rvalid && rready) chk(rdata, d);
      if (rvalid && rready) chk(32'(rresp), 32'(r));
    end
    while (arvalid || rready);
  endtask : axi_rd

  // Compares the design against the reference queue; an asynchronous clear empties it first.
  task automatic check_flags();
    if (async_clear) mq.delete();
    chk(32'(fill_count), 32'(mq.size() % 16));
    chk(32'(empty_flag), 32'(mq.size() == 0));
    chk(32'(full_flag), 32'(mq.size() == 16));
    chk(32'(near_full_flag), 32'(mq.size() >= 12));
    chk(32'(near_empty_flag), 32'(mq.size() < 5));
    chk(32'(read_data_out), 32'(m_rd));
  endtask : check_flags

  // Legacy reference: a full queue refuses writes and an empty one refuses reads.
  always @(posedge aclk)
  begin
    wok = write_request && mq.size() < 16;
    if (!aresetn || async_clear || sync_clear) mq.delete();
    else if (read_request && mq.size() > 0) m_rd = mq.pop_front();
    if (aresetn && !async_clear && !sync_clear && wok) mq.push_back(write_data);
    if (!aresetn) m_rd = 8'h00;
  end

  // Compared mid-cycle, once the edge's updates have landed.
  always @(negedge aclk)
    if (mon_en) check_flags();

  // A hung handshake ends the run as a failure.
  always @(posedge aclk)
  begin
    cycles++;
    if (cycles > 2000) fails++;
    if (cycles > 2000) finish_test();
  end

  // --------------------
  // Scenarios
  // --------------------
  task automatic t_regs();
    axi_rd(8'h00, 32'h06, 2'h0);
    axi_rd(8'h04, 32'ha0, 2'h0);
    axi_rd(8'h0c, 32'h00, 2'h0);
    axi_wr(8'h10, 32'h01, 2'h2);
  endtask : t_regs

  // Fill past full with only the overflow event unmasked, then drain past empty.
  task automatic t_fill();
    axi_wr(8'h0c, 32'h01, 2'h0);
    run(1'b1, 1'b0, 16);
    run(1'b0, 1'b0, 3);
    chk(32'(irq), 32'h0);
    run(1'b1, 1'b0, 2);
    run(1'b0, 1'b0, 3);
    chk(32'(irq), 32'h1);
    axi_rd(8'h04, 32'h50, 2'h0);
    axi_rd(8'h08, 32'h0d, 2'h0);
    axi_wr(8'h08, 32'h0f, 2'h0);
    axi_rd(8'h08, 32'h00, 2'h0);
    chk(32'(irq), 32'h0);
    run(1'b1, 1'b1, 4);
    run(1'b0, 1'b1, 16);
    run(1'b0, 1'b0, 1);
    axi_rd(8'h08, 32'h03, 2'h0);
    axi_wr(8'h08, 32'h03, 2'h0);
  endtask : t_fill

  // Writes keep coming while the asynchronous clear is held.
  task automatic t_clear();
    run(1'b1, 1'b0, 6);
    async_clear <= 1'b1;
    #1;
    check_flags();
    repeat (2) @(posedge aclk);
    async_clear <= 1'b0;
    run(1'b1, 1'b0, 3);
    run(1'b0, 1'b1, 1);
    sync_clear <= 1'b1;
    run(1'b0, 1'b0, 1);
    sync_clear <= 1'b0;
    run(1'b0, 1'b1, 2);
    // The register clear is invisible to the reference, so it is judged by hand.
    run(1'b1, 1'b0, 2);
    run(1'b0, 1'b0, 1);
    mon_en = 1'b0;
    axi_wr(8'h00, 32'h0e, 2'h0);
    mq.delete();
    chk(32'(fill_count), 32'h0);
    chk(32'(empty_flag), 32'h1);
    axi_rd(8'h00, 32'h06, 2'h0);
    mon_en = 1'b1;
  endtask : t_clear

  task automatic t_fwft();
    logic [7:0] a;
    axi_wr(8'h00, 32'h07, 2'h0);
    mon_en = 1'b0;
    run(1'b1, 1'b0, 1);
    a = write_data;
    run(1'b1, 1'b0, 1);
    chk(32'(empty_flag), 32'h1);
    chk(32'(fill_count), 32'h1);
    run(1'b0, 1'b0, 1);
    chk(32'(empty_flag), 32'h0);
    chk(32'(read_data_out), 32'(a));
    run(1'b0, 1'b1, 1);
    run(1'b0, 1'b0, 1);
    chk(32'(read_data_out), 32'(a + 8'h01));
    run(1'b0, 1'b1, 1);
    run(1'b0, 1'b0, 1);
    chk(32'(empty_flag), 32'h1);
    axi_wr(8'h00, 32'h06, 2'h0);
    run(1'b1, 1'b0, 1);
    run(1'b0, 1'b1, 1);
    run(1'b0, 1'b0, 1);
    mon_en = 1'b1;
  endtask : t_fwft

  // Reset for 16 cycles, then the scenarios in turn.
  initial
  begin
    repeat (16) @(posedge aclk);
    aresetn <= 1'b1;
    @(posedge aclk);
    mon_en = 1'b1;
    t_regs();
    t_fill();
    t_clear();
    t_fwft();
    finish_test();
  end
endmodule : scf_fifo_tb_top
